// ===== ubb_pkg.sv
package ubb_pkg;

  // clock and bit-rate scaling
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned BAUD_UNIT_US = 4096;
  localparam int unsigned OVERSAMPLE   = 4;
  // accumulator wrap: clk_hz * 0.004096 s / oversample, kept inside 32 bits
  localparam int unsigned BAUD_MOD_INT = (CLK_HZ / 1000) * BAUD_UNIT_US / 1000 / OVERSAMPLE;
  localparam logic [16:0] BAUD_MOD     = 17'(BAUD_MOD_INT);

  // sample phase counter
  localparam logic [1:0] PH_LAST = 2'(OVERSAMPLE - 1);
  localparam logic [1:0] PH_HALF = 2'(OVERSAMPLE / 2 - 1);

  // standard divisor codes
  localparam logic [15:0] BAUD_9600   = 16'h0027;
  localparam logic [15:0] BAUD_115200 = 16'h01D8;
  localparam logic [15:0] BAUD_921600 = 16'h0EBF;
  localparam logic [15:0] BAUD_RST    = BAUD_115200;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BAUD   = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_TXDATA = 8'h10;
  localparam logic [7:0] ADDR_RXDATA = 8'h14;

  // vendor_config_command code that selects bypass
  localparam logic [15:0] CMD_BYPASS = 16'hB5A5;

  // parity field codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD  = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;

  // frame lengths in bit times, not counting the start bit
  localparam logic [3:0] TX_BASE_LEN = 4'h9;
  localparam logic [3:0] RX_BASE_LEN = 4'h9;

  // status bit positions (write one to clear the error bits)
  localparam int unsigned ST_PAR_ERR   = 4;
  localparam int unsigned ST_FRAME_ERR = 5;

  // pin sync reset and bypass drive pattern (pins 4 and 6 driven)
  localparam logic [3:0] SYNC_RST       = 4'hF;
  localparam logic [3:0] GPIO_OE_BYPASS = 4'h5;

  // control register, bit 0 upward: enable, flow_en, two_stop, parity
  localparam int unsigned CTRL_W = 5;
  typedef struct packed {
    logic [1:0] parity;
    logic       two_stop;
    logic       flow_en;
    logic       enable;
  } ubb_cfg_s;
  localparam ubb_cfg_s CFG_RST = ubb_cfg_s'(5'h01);

  localparam int unsigned STAT_W = 6;
  typedef struct packed {
    logic frame_err;
    logic parity_err;
    logic rx_valid;
    logic tx_busy;
    logic deep_sleep;
    logic bypass;
  } ubb_stat_s;

  typedef enum logic {TX_IDLE, TX_SEND} ubb_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ubb_rx_e;

endpackage : ubb_pkg

// ===== ubb_baud_gen.sv
`timescale 1ns/100ps
module ubb_baud_gen (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // control
  input  wire logic        run,
  input  wire logic [15:0] divisor,
  // oversample tick
  output logic             tick
);

  logic [16:0] acc;
  wire  [16:0] eff_div;
  wire  [16:0] sum;
  wire         wrap;

  // divisors above the wrap saturate at one tick per clock
  assign eff_div = ({1'b0, divisor} > ubb_pkg::BAUD_MOD) ? ubb_pkg::BAUD_MOD : {1'b0, divisor};
  assign sum     = acc + eff_div;
  assign wrap    = sum >= ubb_pkg::BAUD_MOD;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc  <= 17'h00000;
      tick <= 1'b0;
    end else if (!run) begin
      acc  <= 17'h00000;
      tick <= 1'b0;
    end else begin
      acc  <= wrap ? sum - ubb_pkg::BAUD_MOD : sum;
      tick <= wrap;
    end
  end

  a_tick_on_wrap: assert property (@(posedge clk) disable iff (rst)
    run && wrap |=> tick) else $error("tick missing on accumulator wrap");
  a_tick_stopped: assert property (@(posedge clk) disable iff (rst)
    !run |=> !tick && acc == 17'h00000) else $error("tick while stopped");

endmodule : ubb_baud_gen

// ===== ubb_uart_ctrl.sv
`timescale 1ns/100ps
// Function
// - bit rate equals the divisor setting divided by 0.004096.
// - standard rates use fixed codes, e.g. 0x0027, 0x01D8, 0x0EBF.
// - all serial outputs float while chip reset is held.
// - after reset the host serial bus reaches the internal port.
// - bypass command routes host serial signals to general pins 7..4.
// - once bypassed, stay in deep sleep indefinitely with bypass kept.
// - only chip reset leaves bypass and restores default routing.
// - eight data bits, parity none/odd/even, one or two stops.
// - optional active-low request/clear-to-send flow control.
module ubb_uart_ctrl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial port pins
  input  wire logic        uart_rx_in,
  input  wire logic        uart_cts_n_in,
  output logic             uart_tx_out,
  output logic             uart_tx_oe,
  output logic             uart_rts_n_out,
  output logic             uart_rts_n_oe,
  // general_io_pins_7_to_4, index 0 is pin 4
  input  wire logic [3:0]  gpio_in,
  output logic [3:0]       gpio_out,
  output logic [3:0]       gpio_oe,
  // state
  output logic             bypass_active,
  output logic             deep_sleep
);

  // pin synchronisers
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  wire  [3:0] pin_raw = {gpio_in[3], gpio_in[1], uart_cts_n_in, uart_rx_in};
  wire        rx_s    = pin_s2[0];
  wire        cts_n_s = pin_s2[1];
  wire        pio5_s  = pin_s2[2];
  wire        pio7_s  = pin_s2[3];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= ubb_pkg::SYNC_RST;
      pin_s2 <= ubb_pkg::SYNC_RST;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // registers
  ubb_pkg::ubb_cfg_s  cfg;
  ubb_pkg::ubb_stat_s stat;
  logic [15:0]        baud_divisor_setting;
  logic [7:0]         rx_data;
  logic               rx_valid;
  logic               parity_err;
  logic               frame_err;
  logic               bypass;

  // apb decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire hit      = paddr == ubb_pkg::ADDR_CTRL || paddr == ubb_pkg::ADDR_BAUD ||
                  paddr == ubb_pkg::ADDR_CMD || paddr == ubb_pkg::ADDR_STATUS ||
                  paddr == ubb_pkg::ADDR_TXDATA || paddr == ubb_pkg::ADDR_RXDATA;
  wire wr       = access & pwrite;
  wire wr_ctrl  = wr & (paddr == ubb_pkg::ADDR_CTRL);
  wire wr_baud  = wr & (paddr == ubb_pkg::ADDR_BAUD);
  wire wr_stat  = wr & (paddr == ubb_pkg::ADDR_STATUS);
  wire wr_tx    = wr & (paddr == ubb_pkg::ADDR_TXDATA);
  wire rd_rx    = access & ~pwrite & (paddr == ubb_pkg::ADDR_RXDATA);
  wire cmd_byp  = wr & (paddr == ubb_pkg::ADDR_CMD) & (pwdata[15:0] == ubb_pkg::CMD_BYPASS);
  wire run      = cfg.enable & ~bypass;
  wire par_en   = cfg.parity != ubb_pkg::PAR_NONE;
  wire [31:0] rmux;

  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign rmux    = (paddr == ubb_pkg::ADDR_CTRL)   ? {27'h0, cfg} :
                   (paddr == ubb_pkg::ADDR_BAUD)   ? {16'h0, baud_divisor_setting} :
                   (paddr == ubb_pkg::ADDR_STATUS) ? {26'h0, stat} :
                   (paddr == ubb_pkg::ADDR_RXDATA) ? {24'h0, rx_data} : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0 : rmux;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg                  <= ubb_pkg::CFG_RST;
      baud_divisor_setting <= ubb_pkg::BAUD_RST;
    end else begin
      if (wr_ctrl) cfg <= ubb_pkg::ubb_cfg_s'(pwdata[ubb_pkg::CTRL_W-1:0]);
      if (wr_baud) baud_divisor_setting <= pwdata[15:0];
    end
  end

  // bypass is sticky; only reset clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) bypass <= 1'b0;
    else     bypass <= bypass | cmd_byp;
  end
  assign bypass_active = bypass;
  assign deep_sleep    = bypass;

  // rate generator
  logic tick;
  ubb_baud_gen u_baud (
    .clk     (clk),
    .rst     (rst),
    .run     (run),
    .divisor (baud_divisor_setting),
    .tick    (tick)
  );

  // transmitter
  ubb_pkg::ubb_tx_e tx_state;
  logic [7:0]       tx_hold;
  logic             tx_pend;
  logic [11:0]      tx_shift;
  logic [3:0]       tx_cnt;
  logic [1:0]       tx_ph;
  wire  [3:0]       tx_len   = ubb_pkg::TX_BASE_LEN + {3'h0, par_en} + {3'h0, cfg.two_stop};
  wire              tx_par   = (cfg.parity == ubb_pkg::PAR_ODD) ? ~^tx_hold : ^tx_hold;
  wire              tx_line  = (tx_state == ubb_pkg::TX_SEND) ? tx_shift[0] : 1'b1;
  wire              tx_busy  = tx_pend | (tx_state == ubb_pkg::TX_SEND);
  wire              cts_ok   = ~cfg.flow_en | ~cts_n_s;
  wire              tx_bit   = tick & (tx_ph == ubb_pkg::PH_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state <= ubb_pkg::TX_IDLE;
      tx_hold  <= 8'h00;
      tx_pend  <= 1'b0;
      tx_shift <= 12'hFFF;
      tx_cnt   <= 4'h0;
      tx_ph    <= 2'h0;
    end else if (!run) begin
      tx_state <= ubb_pkg::TX_IDLE;
      tx_pend  <= 1'b0;
    end else begin
      if (wr_tx && !tx_busy) begin
        tx_hold <= pwdata[7:0];
        tx_pend <= 1'b1;
      end
      case (tx_state)
        ubb_pkg::TX_IDLE: begin
          if (tx_pend && cts_ok) begin
            tx_shift <= {2'b11, par_en ? tx_par : 1'b1, tx_hold, 1'b0};
            tx_cnt   <= 4'h0;
            tx_ph    <= 2'h0;
            tx_pend  <= 1'b0;
            tx_state <= ubb_pkg::TX_SEND;
          end
        end
        ubb_pkg::TX_SEND: begin
          if (tick) tx_ph <= tx_ph + 2'h1;
          if (tx_bit) begin
            tx_shift <= {1'b1, tx_shift[11:1]};
            tx_cnt   <= tx_cnt + 4'h1;
            if (tx_cnt == tx_len) tx_state <= ubb_pkg::TX_IDLE;
          end
        end
        default: tx_state <= ubb_pkg::TX_IDLE;
      endcase
    end
  end

  // receiver, samples at mid bit after a half-bit start check
  ubb_pkg::ubb_rx_e rx_state;
  logic [9:0]       rx_shift;
  logic [3:0]       rx_cnt;
  logic [1:0]       rx_ph;
  wire  [3:0]       rx_len  = ubb_pkg::RX_BASE_LEN + {3'h0, par_en};
  wire  [9:0]       rx_next = {rx_s, rx_shift[9:1]};
  wire              rx_samp = tick & (rx_ph == ubb_pkg::PH_LAST);
  wire              rx_done = (rx_state == ubb_pkg::RX_DATA) & rx_samp &
                              (rx_cnt == rx_len - 4'h1);
  wire  [7:0]       rx_byte = par_en ? rx_next[7:0] : rx_next[8:1];
  wire              rx_bad_par = par_en &
                              ((cfg.parity == ubb_pkg::PAR_ODD) ? ~^rx_next[8:0] : ^rx_next[8:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state <= ubb_pkg::RX_IDLE;
      rx_shift <= 10'h3FF;
      rx_cnt   <= 4'h0;
      rx_ph    <= 2'h0;
    end else if (!run) begin
      rx_state <= ubb_pkg::RX_IDLE;
    end else begin
      case (rx_state)
        ubb_pkg::RX_IDLE: begin
          rx_ph <= 2'h0;
          if (!rx_s) rx_state <= ubb_pkg::RX_START;
        end
        ubb_pkg::RX_START: begin
          if (tick) rx_ph <= rx_ph + 2'h1;
          if (tick && rx_ph == ubb_pkg::PH_HALF) begin
            rx_ph    <= 2'h0;
            rx_cnt   <= 4'h0;
            rx_state <= rx_s ? ubb_pkg::RX_IDLE : ubb_pkg::RX_DATA;
          end
        end
        ubb_pkg::RX_DATA: begin
          if (tick) rx_ph <= rx_ph + 2'h1;
          if (rx_samp) begin
            rx_shift <= rx_next;
            rx_cnt   <= rx_cnt + 4'h1;
            if (rx_done) rx_state <= ubb_pkg::RX_IDLE;
          end
        end
        default: rx_state <= ubb_pkg::RX_IDLE;
      endcase
    end
  end

  // receive flags: a set in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data    <= 8'h00;
      rx_valid   <= 1'b0;
      parity_err <= 1'b0;
      frame_err  <= 1'b0;
    end else begin
      if (rx_done) rx_data <= rx_byte;
      rx_valid   <= rx_done | (rx_valid & ~rd_rx);
      parity_err <= (rx_done & rx_bad_par) |
                    (parity_err & ~(wr_stat & pwdata[ubb_pkg::ST_PAR_ERR]));
      frame_err  <= (rx_done & ~rx_next[9]) |
                    (frame_err & ~(wr_stat & pwdata[ubb_pkg::ST_FRAME_ERR]));
    end
  end

  assign stat = '{frame_err: frame_err, parity_err: parity_err, rx_valid: rx_valid,
                  tx_busy: tx_busy, deep_sleep: bypass, bypass: bypass};

  // pin drivers: all enables zero under reset so the bus can be shared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uart_tx_out    <= 1'b1;
      uart_tx_oe     <= 1'b0;
      uart_rts_n_out <= 1'b1;
      uart_rts_n_oe  <= 1'b0;
      gpio_out       <= 4'h0;
      gpio_oe        <= 4'h0;
    end else begin
      uart_tx_oe     <= 1'b1;
      uart_rts_n_oe  <= 1'b1;
      uart_tx_out    <= bypass ? pio5_s : tx_line;
      uart_rts_n_out <= bypass ? pio7_s : (cfg.flow_en & rx_valid);
      gpio_out       <= {1'b0, cts_n_s, 1'b0, rx_s};
      gpio_oe        <= bypass ? ubb_pkg::GPIO_OE_BYPASS : 4'h0;
    end
  end

  // checks
  sequence s_bypass_cmd;
    cmd_byp ##1 bypass_active;
  endsequence

  a_reset_float: assert property (@(posedge clk)
    rst |-> !uart_tx_oe && !uart_rts_n_oe && gpio_oe == 4'h0)
    else $error("serial outputs driven during reset");
  // sampled rst keeps the release edge itself out; the pins rise one edge later
  a_default_route: assert property (@(posedge clk) disable iff (rst)
    !rst && !bypass_active |=> uart_tx_oe && uart_rts_n_oe && gpio_oe == 4'h0)
    else $error("default routing lost");
  a_bypass_enter: assert property (@(posedge clk) disable iff (rst)
    s_bypass_cmd |=> gpio_oe == ubb_pkg::GPIO_OE_BYPASS)
    else $error("bypass not routed to general pins");
  a_bypass_sticky: assert property (@(posedge clk) disable iff (rst)
    bypass_active |=> bypass_active && deep_sleep)
    else $error("bypass left without reset");
  a_bypass_pass: assert property (@(posedge clk) disable iff (rst)
    bypass_active |=> uart_tx_out == $past(pio5_s) && gpio_out[0] == $past(rx_s))
    else $error("bypass path not straight through");
  a_sleep_quiet: assert property (@(posedge clk) disable iff (rst)
    deep_sleep |=> tx_state == ubb_pkg::TX_IDLE && rx_state == ubb_pkg::RX_IDLE)
    else $error("port active in deep sleep");
  a_tx_stop_high: assert property (@(posedge clk) disable iff (rst)
    tx_state == ubb_pkg::TX_SEND && tx_cnt >= ubb_pkg::TX_BASE_LEN + {3'h0, par_en}
    |-> tx_line)
    else $error("stop bit not high");
  a_tx_start_low: assert property (@(posedge clk) disable iff (rst)
    $rose(tx_state == ubb_pkg::TX_SEND) |-> !tx_line [*4])
    else $error("start bit malformed");
  a_cts_hold: assert property (@(posedge clk) disable iff (rst)
    tx_state == ubb_pkg::TX_IDLE && tx_pend && cfg.flow_en && cts_n_s
    |=> tx_state == ubb_pkg::TX_IDLE)
    else $error("sent while clear-to-send high");
  a_rx_valid_set: assert property (@(posedge clk) disable iff (rst)
    rx_done |=> rx_valid && rx_data == $past(rx_byte))
    else $error("received byte lost");

endmodule : ubb_uart_ctrl

// ===== ubb_host_model.sv
`timescale 1ns/100ps
module ubb_host_model (
  // clock
  input  wire logic clk,
  // device serial pins
  input  wire logic tx_line, // only listened to; the device drives it alone
  input  wire logic tx_oe,
  output logic      rx_line,
  output logic      cts_n
);
  initial begin
    rx_line = 1'b1;
    cts_n   = 1'b0;
  end

  task automatic set_cts_n(input logic v);
    @(posedge clk);
    cts_n <= v;
  endtask : set_cts_n

  // wrong parity only when the caller asks for a mode the port is not set to
  task automatic send(input logic [7:0] d, input logic [1:0] par, input int bc);
    logic [10:0] f;
    int          nb;
    f  = {1'b1, par == 2'h0 ? 1'b1 : (par == 2'h1 ? ~^d : ^d), d, 1'b0};
    nb = par == 2'h0 ? 10 : 11;
    for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      rx_line <= f[i];
      repeat (bc - 1) @(posedge clk);
    end
  endtask : send

  // samples near mid-bit, so fractional bit periods drift harmlessly
  task automatic recv(input logic [1:0] par, input logic two, input int bc,
                      output logic [7:0] d, output logic p, output logic ok);
    int n;
    n = 0;
    p = 1'b0;
    while (!(tx_line === 1'b0 && tx_oe === 1'b1) && n < 4000) begin
      @(posedge clk);
      n++;
    end
    ok = n < 4000;
    repeat (bc / 2 - 1) @(posedge clk);
    ok &= tx_line === 1'b0;
    for (int i = 0; i < 8; i++) begin
      repeat (bc) @(posedge clk);
      d[i] = tx_line;
    end
    if (par != 2'h0) begin
      repeat (bc) @(posedge clk);
      p = tx_line;
    end
    repeat (bc) @(posedge clk);
    ok &= tx_line === 1'b1;
    if (two) begin
      repeat (bc) @(posedge clk);
      ok &= tx_line === 1'b1;
    end
  endtask : recv
endmodule : ubb_host_model

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, d;
  logic [31:0] pwdata, prdata, rd;
  logic        rxl, ctsn, txo, txoe, rtsn, rtsoe, byp, slp, p, ok;
  logic [3:0]  gin, gout, goe;
  int          bad_count, total_checks;
  localparam logic [15:0] DV [3] = '{16'h6400, ubb_pkg::BAUD_921600, ubb_pkg::BAUD_RST};
  localparam int          BC [3] = '{4, 27, 217};
  localparam logic [7:0]  TB [3] = '{8'h96, 8'h3C, 8'hE1};

  ubb_uart_ctrl ubb_uart_ctrl_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .uart_rx_in(rxl), .uart_cts_n_in(ctsn), .uart_tx_out(txo),
    .uart_tx_oe(txoe), .uart_rts_n_out(rtsn), .uart_rts_n_oe(rtsoe), .gpio_in(gin),
    .gpio_out(gout), .gpio_oe(goe), .bypass_active(byp), .deep_sleep(slp));
  ubb_host_model ubb_host_model_i (.clk(clk), .tx_line(txo), .tx_oe(txoe), .rx_line(rxl),
    .cts_n(ctsn));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), 32'h1);
  endtask : apb

  function automatic logic pbit(input logic [7:0] v, input int m);
    return m == 1 ? ~^v : (m == 2 ? ^v : 1'b0);
  endfunction : pbit

  initial begin
    // scheduled so the registers see a clean rising reset edge at time zero
    rst <= 1'b1;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; gin = 4'hF;
    bad_count = 0; total_checks = 0;
    repeat (12) @(posedge clk);
    chk({txoe, rtsoe, goe}, 32'h00);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({txoe, rtsoe, byp, slp}, 32'hC);
    apb(1'b0, ubb_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h01);
    apb(1'b0, ubb_pkg::ADDR_BAUD, 32'h0);
    chk(rd, 32'h01D8);
    apb(1'b0, 8'h18, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    // every parity mode, two stops last, three divisor codes
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ubb_pkg::ADDR_BAUD, 32'(DV[i]));
      apb(1'b1, ubb_pkg::ADDR_CTRL, 32'(1 + 8 * i + 4 * (i == 2)));
      apb(1'b1, ubb_pkg::ADDR_TXDATA, 32'(TB[i]));
      ubb_host_model_i.recv(2'(i), i == 2, BC[i], d, p, ok);
      chk({ok, p, d}, {1'b1, pbit(TB[i], i), TB[i]});
      // let the stop bits finish, else the next data write meets tx_busy
      repeat (2 * BC[i]) @(posedge clk);
    end
    apb(1'b1, ubb_pkg::ADDR_BAUD, 32'h6400);
    apb(1'b1, ubb_pkg::ADDR_CTRL, 32'h13);
    ubb_host_model_i.set_cts_n(1'b1);
    apb(1'b1, ubb_pkg::ADDR_TXDATA, 32'h5A);
    repeat (100) @(posedge clk);
    apb(1'b0, ubb_pkg::ADDR_STATUS, 32'h0);
    chk({txo, rd[2]}, 32'h3);
    ubb_host_model_i.set_cts_n(1'b0);
    ubb_host_model_i.recv(2'h2, 1'b0, 4, d, p, ok);
    chk({ok, p, d}, {1'b1, pbit(8'h5A, 2), 8'h5A});
    ubb_host_model_i.send(8'hC3, 2'h2, 4);
    repeat (8) @(posedge clk);
    chk(rtsn, 32'h1);
    apb(1'b0, ubb_pkg::ADDR_RXDATA, 32'h0);
    chk(rd, 32'hC3);
    repeat (3) @(posedge clk);
    chk(rtsn, 32'h0);
    ubb_host_model_i.send(8'h0F, 2'h1, 4);
    repeat (8) @(posedge clk);
    apb(1'b0, ubb_pkg::ADDR_STATUS, 32'h0);
    chk(rd[5:3], 32'h3);
    apb(1'b1, ubb_pkg::ADDR_STATUS, 32'h10);
    apb(1'b0, ubb_pkg::ADDR_RXDATA, 32'h0);
    apb(1'b0, ubb_pkg::ADDR_STATUS, 32'h0);
    chk(rd[5:2], 32'h0);
    apb(1'b1, ubb_pkg::ADDR_CMD, 32'h1234);
    repeat (4) @(posedge clk);
    chk(byp, 32'h0);
    apb(1'b1, ubb_pkg::ADDR_CMD, 32'(ubb_pkg::CMD_BYPASS)); // no link open here
    gin <= 4'h5;
    repeat (500) @(posedge clk);
    chk({byp, slp, goe, txo, rtsn, gout[0], gout[2]}, 32'h352);
    ubb_host_model_i.set_cts_n(1'b1);
    gin <= 4'hF;
    repeat (5) @(posedge clk);
    chk({gout[2], txo, rtsn}, 32'h7);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({txoe, rtsoe, goe, byp}, 32'h0);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b0, ubb_pkg::ADDR_STATUS, 32'h0);
    chk({txoe, goe, rd[1:0]}, 32'h40);
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule : tb_top
